// file: verilog/sdl_pkg.sv
// constants shared by the seven-to-one display link receiver
package sdl_pkg;

    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    localparam int CORE_CLK_MHZ = 250;
    localparam int CORE_PERIOD_PS = 1000000 / CORE_CLK_MHZ;

    // ------------------------------------------------------------
    // link shape
    // ------------------------------------------------------------
    localparam int BITS_PER_LANE = 7;
    localparam int LANES_WIDE = 4;
    localparam int LANES_NARROW = 3;
    localparam int LINK_MIN_MHZ = 20;
    localparam int LINK_MAX_MHZ = 85;
    // nominal strobe points at top rate; bit k sits at (2k+1)/14 of period
    localparam int SAMPLE_BIT0_PS = 840;
    localparam int SAMPLE_BIT6_PS = 10920;
    localparam int SAMPLE_SLOTS = 2 * BITS_PER_LANE;
    // fewest core cycles per link cycle that can hold seven strobes
    localparam int MIN_PERIOD_CYCLES = SAMPLE_SLOTS;
    localparam int PERIOD_W = 12;

    // ------------------------------------------------------------
    // timing limits
    // ------------------------------------------------------------
    localparam int REGEN_DELAY_NOM_PS = 7000;
    localparam int REGEN_DELAY_MAX_PS = 9500;
    // clock out is the second synchroniser stage: at most two core periods
    localparam int REGEN_DELAY_CYCLES = 2;
    localparam int LOCK_TIME_MS = 10;
    localparam int LOCK_TIME_CYCLES = LOCK_TIME_MS * CORE_CLK_MHZ * 1000;
    localparam int LOCK_STABLE_LINK = 16;
    localparam int PD_LATENCY_NS = 1000;
    localparam int PD_LATENCY_CYCLES = PD_LATENCY_NS * 1000 / CORE_PERIOD_PS;
    // cycles from power-down pin to cleared outputs: two sync, one load
    localparam int PD_PATH_CYCLES = 3;
    localparam int LOSS_CYCLES = 4000;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [PERIOD_W-1:0] PERIOD_RESET = 12'h000;

endpackage

// file: verilog/sdl_receiver.sv
// seven-to-one display link receiver: deserialiser, lock and output stage
//
// Functional notes
// RL1 - four lanes give 28 outputs with spare
// RL2 - three lanes give 21 outputs, no spare
// RL3 - forwarded link clock times all data lanes
// RL4 - lock to link clock, 20 to 85 MHz; code locks only at 14 or more core cycles per link cycle
// RL5 - seven bits per lane per link cycle
// RL6 - deserialise only once lock is held
// RL7 - strobes evenly spaced at (2k+1)/14 period
// RL8 - outputs change on regenerated clock falling edge
// RL9 - regenerated clock lags link clock under 9.5 ns
// RL10 - lock and valid outputs within 10 ms
// RL11 - power-down low enters low power any time
// RL12 - power-down takes effect within 1 us
// RL13 - clocks stop: outputs hold their last values
// RL14 - transmitter clock jitter below 250 ps
// RL15 - outputs held low while powered down
// RL16 - fixed table maps lane bits to outputs
`timescale 1ns/1ps
`default_nettype none

module sdl_receiver
    import sdl_pkg::*;
#(
    parameter int LANES = LANES_WIDE,
    parameter int LOCK_LIMIT_CYCLES = LOCK_TIME_CYCLES,
    parameter int LOCK_LINK_CYCLES = LOCK_STABLE_LINK,
    parameter int LOSS_TIMEOUT = LOSS_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic link_clock_in,
    input wire logic [LANES-1:0] serial_data_pairs_in,
    input wire logic power_down_n_in,
    output logic [LANES*BITS_PER_LANE-1:0] parallel_outputs_out,
    output logic regen_out_clock_out,
    output logic pll_locked_out
);

    // internal widths
    localparam int OUT_W = LANES * BITS_PER_LANE;
    localparam int PW = PERIOD_W;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // refuse shapes that the counters or the timing limits cannot hold
    generate
        if (LANES != LANES_WIDE && LANES != LANES_NARROW) begin : g_bad_lanes
            $error("sdl_receiver: LANES must be 3 or 4");
        end
        if (LOCK_LINK_CYCLES < 1 || LOCK_LINK_CYCLES > 255) begin : g_bad_lock
            $error("sdl_receiver: LOCK_LINK_CYCLES out of range");
        end
        if (LOCK_LINK_CYCLES * (2 ** PW) > LOCK_LIMIT_CYCLES) begin : g_slow
            $error("sdl_receiver: lock could exceed its time limit");
        end
        if (LOSS_TIMEOUT >= 2 ** PW || LOSS_TIMEOUT <= MIN_PERIOD_CYCLES)
        begin : g_bad_loss
            $error("sdl_receiver: LOSS_TIMEOUT out of range");
        end
        if (REGEN_DELAY_CYCLES * CORE_PERIOD_PS > REGEN_DELAY_MAX_PS)
        begin : g_bad_delay
            $error("sdl_receiver: clock out delay too long");
        end
        if (PD_PATH_CYCLES > PD_LATENCY_CYCLES) begin : g_bad_pd
            $error("sdl_receiver: power-down path too slow");
        end
        if ((2 ** PW - 1) * (SAMPLE_SLOTS - 1) >= 2 ** (PW + 4))
        begin : g_bad_width
            $error("sdl_receiver: strobe product overflows");
        end
    endgenerate

    // ------------------------------------------------------------
    // link domain: one toggle per link clock cycle
    // ------------------------------------------------------------
    logic link_rst_s1;
    logic link_rst;
    logic link_toggle;

    // reset leaves the link domain in step with its own clock
    always_ff @(posedge link_clock_in or posedge rst_in) begin
        if (rst_in) begin
            link_rst_s1 <= 1'b1;
            link_rst <= 1'b1;
        end else begin
            link_rst_s1 <= 1'b0;
            link_rst <= link_rst_s1;
        end
    end

    // marks each forwarded clock cycle as an event for the core side
    always_ff @(posedge link_clock_in or posedge link_rst) begin
        if (link_rst) begin
            link_toggle <= 1'b0;
        end else begin
            link_toggle <= ~link_toggle; // RL3
        end
    end

    // ------------------------------------------------------------
    // crossings into the core domain
    // ------------------------------------------------------------
    logic tog_s1, tog_s2, tog_s3;
    logic clk_s1, clk_s2, clk_s3;
    logic [LANES-1:0] data_s1, data_s2;
    logic pd_s1, pd_s2;

    // link toggle: two stages, the third only finds its edges
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            tog_s1 <= link_toggle;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    // clock level; low reset value matches a parked clock
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
        end else begin
            clk_s1 <= link_clock_in;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
        end
    end

    // serial lanes: two stages, as late as the toggle event
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_s1 <= '0;
            data_s2 <= '0;
        end else begin
            data_s1 <= serial_data_pairs_in;
            data_s2 <= data_s1;
        end
    end

    // power-down pin: asleep until the pin is seen high
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pd_s1 <= 1'b0;
            pd_s2 <= 1'b0;
        end else begin
            pd_s1 <= power_down_n_in;
            pd_s2 <= pd_s1;
        end
    end

    logic cycle_evt;
    logic regen_fall;
    logic awake;

    // one-cycle strobes for cycle start and clock fall
    assign cycle_evt = tog_s2 ^ tog_s3;
    assign regen_fall = clk_s3 & ~clk_s2;
    assign awake = pd_s2; // RL11

    // ------------------------------------------------------------
    // period measurement and lock
    // ------------------------------------------------------------
    // counters in core cycles; stable_cnt counts link cycles
    logic [PW-1:0] phase;
    logic [PW-1:0] period;
    logic [PW-1:0] meas;
    logic [PW-1:0] delta;
    logic [7:0] stable_cnt;
    logic locked;
    logic lost;

    // length of the cycle now ending, and the stall marker
    assign meas = phase + 1'b1;
    assign delta = (meas > period) ? (meas - period) : (period - meas);
    assign lost = (phase == PW'(LOSS_TIMEOUT));

    // core cycles since the last link cycle start, saturating on loss
    // saturation keeps a stopped link from wrapping into a lock
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase <= PERIOD_RESET;
        end else if (cycle_evt) begin
            phase <= PERIOD_RESET;
        end else if (!lost) begin
            phase <= phase + 1'b1;
        end
    end

    // period follows each measured cycle
    // a jump beyond one cycle is caught by the lock logic
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            period <= PERIOD_RESET;
        end else if (cycle_evt) begin
            period <= meas; // RL4
        end
    end

    // lock once the period stays within one cycle for a run of cycles
    // a cut or jumping clock restarts the count
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            stable_cnt <= 8'h00;
            locked <= 1'b0;
        end else if (!awake || lost) begin
            stable_cnt <= 8'h00; // RL12
            locked <= 1'b0;
        end else if (cycle_evt) begin
            if (delta <= PW'(1) && meas >= PW'(MIN_PERIOD_CYCLES)) begin
                if (stable_cnt >= 8'(LOCK_LINK_CYCLES)) begin
                    locked <= 1'b1; // RL10
                end else begin
                    stable_cnt <= stable_cnt + 8'h01;
                end
            end else begin
                stable_cnt <= 8'h00;
                locked <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // strobe positions, one per bit slot
    // ------------------------------------------------------------
    logic [PW-1:0] strobe_pos [BITS_PER_LANE];

    generate
        for (genvar k = 0; k < BITS_PER_LANE; k++) begin : g_pos
            localparam logic [PW+3:0] ODD = (PW+4)'(2 * k + 1);
            localparam logic [PW+3:0] DIV = (PW+4)'(SAMPLE_SLOTS);
            logic [PW+3:0] pos_wide;
            // product wide enough for the longest period
            assign pos_wide = {4'h0, period} * ODD;
            // centre of slot k within the measured period
            always_ff @(posedge core_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    strobe_pos[k] <= PERIOD_RESET;
                end else begin
                    strobe_pos[k] <= PW'(pos_wide / DIV); // RL7
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // sampling into a per-cycle shadow word
    // ------------------------------------------------------------
    logic [LANES-1:0] slot_bits [BITS_PER_LANE];
    logic [OUT_W-1:0] shadow;

    generate
        for (genvar k = 0; k < BITS_PER_LANE; k++) begin : g_slot
            logic strobe_hit;
            // slot k comes round once per link cycle
            assign strobe_hit = (phase == strobe_pos[k]);
            // seven strobes per lane per cycle, only under lock
            always_ff @(posedge core_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    slot_bits[k] <= '0;
                end else if (locked && strobe_hit) begin
                    slot_bits[k] <= data_s2; // RL5
                end
            end
            // lane l bit k lands on output l*7+k; lane 3 is the spare
            for (genvar l = 0; l < LANES; l++) begin : g_map
                assign shadow[l*BITS_PER_LANE+k] = slot_bits[k][l]; // RL16
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // word hand-off and output stage
    // ------------------------------------------------------------
    logic sampled_ok;
    logic [OUT_W-1:0] pending;
    logic pending_valid;
    logic [OUT_W-1:0] word_out;
    logic active;

    // a full cycle was sampled under lock
    // the cycle in which lock comes may be only partly sampled
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sampled_ok <= 1'b0;
        end else if (!locked) begin
            sampled_ok <= 1'b0;
        end else if (cycle_evt) begin
            sampled_ok <= 1'b1; // RL6
        end
    end

    // finished word waits for the next falling edge of clock out
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pending <= '0;
            pending_valid <= 1'b0;
        end else if (!awake || !locked) begin
            pending_valid <= 1'b0; // no word survives a loss of lock
        end else if (cycle_evt && sampled_ok && locked) begin
            pending <= shadow; // RL1 RL2
            pending_valid <= 1'b1;
        end
    end

    // load on falling edge; cleared in power-down; else held
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            word_out <= '0;
        end else if (!awake) begin
            word_out <= '0; // RL15
        end else if (regen_fall && pending_valid && active && locked) begin
            word_out <= pending; // RL8
        end
    end

    // clock out is gated by lock; loss of lock leaves data held
    // a runt pulse on clock out would clip the downstream capture
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            active <= 1'b0;
        end else if (!clk_s2) begin
            active <= locked && awake; // follow lock while clock is low; power-down clears at any level
        end else if (!awake) begin
            active <= 1'b0;
        end
    end

    // data and lock straight from registers; clock out is clk_s2 gated by active
    assign parallel_outputs_out = word_out; // RL13
    assign regen_out_clock_out = clk_s2 & active; // RL9
    assign pll_locked_out = locked;

endmodule

`default_nettype wire

// file: test/sdl_receiver_assertions.sv
// port checker for the display link receiver
`timescale 1ns/1ps
`default_nettype none
module sdl_receiver_checker
    import sdl_pkg::*;
#(parameter int LANES = LANES_WIDE,
    parameter int LOSS_TIMEOUT = LOSS_CYCLES) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic link_clock_in,
    input wire logic [LANES-1:0] serial_data_pairs_in,
    input wire logic power_down_n_in,
    input wire logic [LANES*BITS_PER_LANE-1:0] parallel_outputs_out,
    input wire logic regen_out_clock_out,
    input wire logic pll_locked_out
);
    // ------
    // helpers and properties
    // ------
    logic [15:0] idle;
    logic link_q;
    // core cycles since the link clock last moved
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            idle <= 16'h0000;
            link_q <= 1'b0;
        end else begin
            link_q <= link_clock_in;
            idle <= (link_q != link_clock_in) ? 16'h0000 :
                ((idle == 16'hffff) ? idle : idle + 16'h0001);
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_pd_held;
        !power_down_n_in [*5];
    endsequence
    sequence s_dark;
        (!pll_locked_out && !regen_out_clock_out) ##1 !pll_locked_out;
    endsequence
    property p_pd_clear;
        s_pd_held |-> parallel_outputs_out == '0 && !pll_locked_out;
    endproperty
    a_pd_clear: assert property (p_pd_clear)
        else $error("outputs not cleared in power-down");
    property p_out_on_fall;
        pll_locked_out && $changed(parallel_outputs_out) |->
            !$past(regen_out_clock_out) &&
            ($past(regen_out_clock_out, 2) || $past(regen_out_clock_out, 3));
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("outputs changed away from clock fall");
    property p_regen_rise;
        $rose(link_clock_in) && pll_locked_out && power_down_n_in |->
            ##[1:2] regen_out_clock_out;
    endproperty
    a_regen_rise: assert property (p_regen_rise)
        else $error("clock out rise too late");
    property p_regen_fall;
        $fell(link_clock_in) |-> ##[1:2] !regen_out_clock_out;
    endproperty
    a_regen_fall: assert property (p_regen_fall)
        else $error("clock out fall too late");
    property p_hold_unlocked;
        !pll_locked_out && !$past(pll_locked_out) |->
            $stable(parallel_outputs_out) || parallel_outputs_out == '0;
    endproperty
    a_hold_unlocked: assert property (p_hold_unlocked)
        else $error("word produced without lock");
    property p_loss;
        int'(idle) > LOSS_TIMEOUT + 8 |-> !pll_locked_out;
    endproperty
    a_loss: assert property (p_loss)
        else $error("lock kept with clock stopped");
    property p_lock_need;
        $rose(pll_locked_out) |->
            $past(power_down_n_in, 3) && idle < 16'h0040;
    endproperty
    a_lock_need: assert property (p_lock_need)
        else $error("lock without running clock");
    property p_regen_low;
        s_dark |-> !regen_out_clock_out;
    endproperty
    a_regen_low: assert property (p_regen_low)
        else $error("clock out runs without lock");
endmodule
bind sdl_receiver sdl_receiver_checker #(.LANES(LANES),
    .LOSS_TIMEOUT(LOSS_TIMEOUT)) u_chk (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .link_clock_in(link_clock_in),
    .serial_data_pairs_in(serial_data_pairs_in),
    .power_down_n_in(power_down_n_in),
    .parallel_outputs_out(parallel_outputs_out),
    .regen_out_clock_out(regen_out_clock_out),
    .pll_locked_out(pll_locked_out));
`default_nettype wire

// file: test/sdl_tx_model.sv
// transmitter model: seven bits per lane per link cycle
`timescale 1ns/1ps
`default_nettype none
module sdl_tx_model (
    input wire logic run_in,
    input wire logic [27:0] word_in,
    output logic link_clk_out,
    output logic [3:0] lanes_out
);
    // ------
    // half-slot sequencer
    // ------
    initial begin
        logic [27:0] w;
        link_clk_out = 1'b0;
        lanes_out = 4'h5;
        w = 28'h0000000;
        #3.3;
        forever begin
            if (run_in) begin
                // clock high for seven half slots, no jitter
                for (int h = 0; h < 14; h++) begin
                    if (h == 0) begin
                        w = word_in;
                    end
                    link_clk_out = (h < 7);
                    // bit k of each lane in slot k
                    for (int l = 0; l < 4; l++) begin
                        lanes_out[l] = w[l*7+h/2];
                    end
                    #(160.0/14.0);
                end
            end else begin
                // clock parked low, idle lines keep moving
                link_clk_out = 1'b0;
                lanes_out = ~lanes_out;
                #(160.0/14.0);
            end
        end
    end
endmodule
`default_nettype wire

// file: test/test_sdl_receiver.sv
// self-checking bench for the display link receiver
`timescale 1ns/1ps
`default_nettype none
module test_sdl_receiver;
    import sdl_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic pd_n = 1'b1;
    logic run = 1'b0;
    logic [27:0] word = 28'h0000000;
    wire link_clk;
    wire [3:0] lanes;
    wire [27:0] dout;
    wire [20:0] nout;
    wire regen, lock, n_regen, n_lock;
    int err_total = 0;
    int total_checks = 0;
    // ------
    // clock, partner and both variants
    // ------
    initial begin
        forever #2 core_clk_in = ~core_clk_in;
    end
    sdl_tx_model u_tx (.run_in(run), .word_in(word),
        .link_clk_out(link_clk), .lanes_out(lanes));
    sdl_receiver #(.LOCK_LINK_CYCLES(2), .LOSS_TIMEOUT(100)) u_dut (
        .core_clk_in(core_clk_in), .rst_in(rst_in),
        .link_clock_in(link_clk), .serial_data_pairs_in(lanes),
        .power_down_n_in(pd_n), .parallel_outputs_out(dout),
        .regen_out_clock_out(regen), .pll_locked_out(lock));
    sdl_receiver #(.LANES(3), .LOCK_LINK_CYCLES(2), .LOSS_TIMEOUT(100))
        u_narrow (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .link_clock_in(link_clk), .serial_data_pairs_in(lanes[2:0]),
        .power_down_n_in(pd_n), .parallel_outputs_out(nout),
        .regen_out_clock_out(n_regen), .pll_locked_out(n_lock));
    // ------
    // shared tasks
    // ------
    task automatic results();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [27:0] seen, input logic [27:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wait_lock();
        for (int n = 0; !(lock === 1'b1 && n_lock === 1'b1); n++) begin
            @(negedge core_clk_in);
            if (n > 4000) begin
                err_total++;
                results();
            end
        end
    endtask
    task automatic see_word(input logic [27:0] w);
        logic prev;
        int falls;
        word = w;
        prev = regen;
        falls = 0;
        for (int n = 0; falls < 3; n++) begin
            @(negedge core_clk_in);
            falls += (prev === 1'b1 && regen === 1'b0) ? 1 : 0;
            prev = regen;
            if (n > 2000) begin
                err_total++;
                results();
            end
        end
        repeat (2) @(negedge core_clk_in);
        check(dout, w);
        check({7'h00, nout}, {7'h00, w[20:0]});
    endtask
    // ------
    // scenarios
    // ------
    task automatic t_unlocked();
        check(dout, 28'h0000000);
        word = 28'h5555555;
        run = 1'b1;
        repeat (20) @(negedge core_clk_in);
        check({dout[27:2], regen, lock}, 28'h0000000);
        wait_lock();
    endtask
    task automatic t_data();
        logic [27:0] pats [4];
        pats = '{28'h5555555, 28'haaaaaaa, 28'h8102041, 28'hfedcba9};
        foreach (pats[i]) begin
            see_word(pats[i]);
        end
    endtask
    task automatic t_powerdown();
        pd_n = 1'b0;
        repeat (PD_PATH_CYCLES + 2) @(negedge core_clk_in);
        check(dout, 28'h0000000);
        repeat (25) @(negedge core_clk_in);
        check({dout[27:2], regen, lock}, 28'h0000000);
        pd_n = 1'b1;
        wait_lock();
        see_word(28'h1234567);
    endtask
    task automatic t_stop();
        see_word(28'h0f0f0f0);
        run = 1'b0;
        repeat (50) @(negedge core_clk_in);
        check(dout, 28'h0f0f0f0);
        repeat (250) @(negedge core_clk_in);
        check({dout, regen, lock}, {28'h0f0f0f0, 2'b00});
        run = 1'b1;
        wait_lock();
        see_word(28'h7654321);
    endtask
    initial begin
        repeat (2) @(negedge core_clk_in);
        rst_in = 1'b0;
        t_unlocked();
        t_data();
        t_powerdown();
        t_stop();
        results();
    end
endmodule
`default_nettype wire
